/* logic/bcer_regs.sv */
`timescale 1ns/1ns
module bcer_regs import bcer_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic [7:0] error_events,
  input wire logic [7:0] error_mask,
  input wire logic system_error_enable,
  output logic [9:0] secondary_clock_outputs,
  output logic primary_system_error_out,
  output logic primary_memr_alias,
  output logic primary_memw_alias,
  output logic secondary_memr_alias
);
  // ****************************************
  // state
  // ****************************************
  bcer_state_type state;
  bcer_state_type next_state;
  logic [7:0] raise;
  logic [9:0] run;

  // ****************************************
  // gating decode
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < BCER_NUM_CLOCKS; gi = gi + 1) begin : g_clk
      if (gi < BCER_NUM_GATED) begin : g_pair
        assign run[gi] = ~(&state.clock_gating[2*gi +: 2]);
      end else begin : g_single
        assign run[gi] = ~state.clock_gating[BCER_POS_SINGLE + gi - BCER_NUM_GATED];
      end
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    // events raise the error line only when unmasked and enabled
    raise = error_events & ~error_mask & {BCER_NUM_CAUSES{system_error_enable}};
    if (cfg_write && cfg_addr == BCER_OFS_CLOCK_STATUS) begin
      if (cfg_byte_en[0]) begin
        next_state.clock_gating[7:0] = cfg_wdata[7:0];
      end
      if (cfg_byte_en[1]) begin
        next_state.clock_gating[13:8] = cfg_wdata[13:8];
      end
      if (cfg_byte_en[2]) begin
        next_state.causes = state.causes & ~cfg_wdata[23:16];
      end
    end else if (cfg_write && cfg_addr == BCER_OFS_PORT_OPTION) begin
      if (cfg_byte_en[0]) begin
        next_state.options = cfg_wdata[3:1];
      end
    end
    // set wins over a simultaneous clear
    next_state.causes = next_state.causes | raise;
    next_state.read_data = 32'h00000000;
    if (cfg_read && cfg_addr == BCER_OFS_CLOCK_STATUS) begin
      next_state.read_data = {8'h00, state.causes, 2'b00, state.clock_gating};
    end else if (cfg_read && cfg_addr == BCER_OFS_PORT_OPTION) begin
      next_state.read_data = {28'h0000000, state.options, 1'b0};
    end
    next_state.clock_enable = run;
    next_state.primary_system_error_out = |raise;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state.clock_gating <= BCER_RST_CLOCK_GATING;
      state.causes <= BCER_RST_CAUSES;
      state.options <= BCER_RST_OPTIONS;
      state.read_data <= BCER_RST_READ_DATA;
      state.clock_enable <= BCER_RST_CLOCK_ENABLE;
      state.primary_system_error_out <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // stopped clocks are held low by gating the enable with the clock
  assign secondary_clock_outputs = state.clock_enable & {BCER_NUM_CLOCKS{sys_clk}};
  assign cfg_rdata = state.read_data;
  assign primary_system_error_out = state.primary_system_error_out;
  assign primary_memr_alias = state.options[BCER_OPT_PRI_MEMR];
  assign primary_memw_alias = state.options[BCER_OPT_PRI_MEMW];
  assign secondary_memr_alias = state.options[BCER_OPT_SEC_MEMR];

  // ****************************************
  // checks
  // ****************************************
  property p_pair_gate;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[0] == ~(&$past(state.clock_gating[1:0]));
  endproperty
  a_pair_gate: assert property (p_pair_gate) else $error("pair gate wrong");

  property p_single_gate;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[9] == ~$past(state.clock_gating[13]);
  endproperty
  a_single_gate: assert property (p_single_gate) else $error("single gate wrong");

  property p_reserved_clk;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && cfg_read && cfg_addr == BCER_OFS_CLOCK_STATUS) |=> cfg_rdata[15:14] == 2'b00;
  endproperty
  a_reserved_clk: assert property (p_reserved_clk) else $error("reserved bits nonzero");

  property p_cause_set;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && raise[0]) |=> state.causes[0] && primary_system_error_out;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause not latched");

  property p_abort_gate;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && error_events[BCER_CAUSE_TARGET_ABORT] && !error_mask[BCER_CAUSE_TARGET_ABORT] && system_error_enable)
      |=> primary_system_error_out && state.causes[BCER_CAUSE_TARGET_ABORT];
  endproperty
  a_abort_gate: assert property (p_abort_gate) else $error("abort not raised");

  property p_no_raise_disabled;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && !system_error_enable) |=> !primary_system_error_out;
  endproperty
  a_no_raise_disabled: assert property (p_no_raise_disabled) else $error("raised while disabled");

  property p_sticky;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && state.causes[5] && !(cfg_write && cfg_addr == BCER_OFS_CLOCK_STATUS && cfg_byte_en[2] && cfg_wdata[21]))
      |=> state.causes[5];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_clear;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && cfg_write && cfg_addr == BCER_OFS_CLOCK_STATUS && cfg_byte_en[2] && cfg_wdata[23] && !raise[7])
      |=> !state.causes[7];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_opt_bit0;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && cfg_read && cfg_addr == BCER_OFS_PORT_OPTION) |=> cfg_rdata[0] == 1'b0 && cfg_rdata[3:1] == $past(state.options);
  endproperty
  a_opt_bit0: assert property (p_opt_bit0) else $error("option readback wrong");

  property p_pair_gate1;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[1] == ~(&$past(state.clock_gating[3:2]));
  endproperty
  a_pair_gate1: assert property (p_pair_gate1) else $error("pair gate 1 wrong");

  property p_pair_gate2;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[2] == ~(&$past(state.clock_gating[5:4]));
  endproperty
  a_pair_gate2: assert property (p_pair_gate2) else $error("pair gate 2 wrong");

  property p_pair_gate3;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[3] == ~(&$past(state.clock_gating[7:6]));
  endproperty
  a_pair_gate3: assert property (p_pair_gate3) else $error("pair gate 3 wrong");

  property p_single_gate4;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[4] == ~$past(state.clock_gating[8]);
  endproperty
  a_single_gate4: assert property (p_single_gate4) else $error("single gate 4 wrong");

  property p_single_gate5;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[5] == ~$past(state.clock_gating[9]);
  endproperty
  a_single_gate5: assert property (p_single_gate5) else $error("single gate 5 wrong");

  property p_single_gate6;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[6] == ~$past(state.clock_gating[10]);
  endproperty
  a_single_gate6: assert property (p_single_gate6) else $error("single gate 6 wrong");

  property p_single_gate7;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[7] == ~$past(state.clock_gating[11]);
  endproperty
  a_single_gate7: assert property (p_single_gate7) else $error("single gate 7 wrong");

  property p_single_gate8;
    @(posedge sys_clk) disable iff (!resetn)
    clk_en |=> state.clock_enable[8] == ~$past(state.clock_gating[12]);
  endproperty
  a_single_gate8: assert property (p_single_gate8) else $error("single gate 8 wrong");

  property p_cause_set1;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && raise[1]) |=> state.causes[1] && primary_system_error_out;
  endproperty
  a_cause_set1: assert property (p_cause_set1) else $error("cause 1 not latched");

  property p_cause_set2;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && raise[2]) |=> state.causes[2] && primary_system_error_out;
  endproperty
  a_cause_set2: assert property (p_cause_set2) else $error("cause 2 not latched");

  property p_cause_set4;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && raise[4]) |=> state.causes[4] && primary_system_error_out;
  endproperty
  a_cause_set4: assert property (p_cause_set4) else $error("cause 4 not latched");

  property p_cause_set5;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && raise[5]) |=> state.causes[5] && primary_system_error_out;
  endproperty
  a_cause_set5: assert property (p_cause_set5) else $error("cause 5 not latched");

  property p_cause_set6;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && raise[6]) |=> state.causes[6] && primary_system_error_out;
  endproperty
  a_cause_set6: assert property (p_cause_set6) else $error("cause 6 not latched");

  property p_cause_set7;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && raise[7]) |=> state.causes[7] && primary_system_error_out;
  endproperty
  a_cause_set7: assert property (p_cause_set7) else $error("cause 7 not latched");

  property p_zero_keeps;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && state.causes[0] && cfg_write && cfg_addr == BCER_OFS_CLOCK_STATUS && !cfg_wdata[16]) |=> state.causes[0];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

  property p_clear_isolated;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && cfg_write && cfg_addr == BCER_OFS_CLOCK_STATUS && cfg_byte_en[2] && cfg_wdata[23:16] == 8'h08)
      |=> (state.causes & 8'hf7) == (($past(state.causes) | $past(raise)) & 8'hf7);
  endproperty
  a_clear_isolated: assert property (p_clear_isolated) else $error("clear disturbed other flag");

  property p_opt_pri_memr;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && cfg_write && cfg_addr == BCER_OFS_PORT_OPTION && cfg_byte_en[0]) |=> primary_memr_alias == $past(cfg_wdata[1]);
  endproperty
  a_opt_pri_memr: assert property (p_opt_pri_memr) else $error("primary read alias wrong");

  property p_opt_pri_memw;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && cfg_write && cfg_addr == BCER_OFS_PORT_OPTION && cfg_byte_en[0]) |=> primary_memw_alias == $past(cfg_wdata[2]);
  endproperty
  a_opt_pri_memw: assert property (p_opt_pri_memw) else $error("primary write alias wrong");

  property p_opt_sec_memr;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && cfg_write && cfg_addr == BCER_OFS_PORT_OPTION && cfg_byte_en[0]) |=> secondary_memr_alias == $past(cfg_wdata[3]);
  endproperty
  a_opt_sec_memr: assert property (p_opt_sec_memr) else $error("secondary read alias wrong");

  property p_opt_hold;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && !(cfg_write && cfg_addr == BCER_OFS_PORT_OPTION)) |=> state.options == $past(state.options);
  endproperty
  a_opt_hold: assert property (p_opt_hold) else $error("option changed without write");

  property p_raise_masked;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && (error_events & ~error_mask) == 8'h00) |=> !primary_system_error_out;
  endproperty
  a_raise_masked: assert property (p_raise_masked) else $error("raised for masked event");

  property p_abort_masked;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && error_mask[BCER_CAUSE_TARGET_ABORT] && !state.causes[BCER_CAUSE_TARGET_ABORT])
      |=> !state.causes[BCER_CAUSE_TARGET_ABORT];
  endproperty
  a_abort_masked: assert property (p_abort_masked) else $error("masked abort latched");

  property p_opt_upper;
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && cfg_read && cfg_addr == BCER_OFS_PORT_OPTION) |=> cfg_rdata[31:4] == 28'h0000000;
  endproperty
  a_opt_upper: assert property (p_opt_upper) else $error("option upper bits nonzero");

  c_option_write: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(primary_memw_alias));
  c_masked_event: cover property (@(posedge sys_clk) disable iff (!resetn) error_events[3] && error_mask[3]);
  c_disable_clock: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(state.clock_enable[4]));
  c_error_raise: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(primary_system_error_out));
  c_clear_flag: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(state.causes[2]));
endmodule : bcer_regs

/* logic/bcer_pkg.sv */
// Overview of operation
// - clock outputs 0-3 each use a bit pair; both bits set disables it.
// - clock outputs 4-9 use bits 8-13; a set bit stops and holds low.
// - bits 15:14 of the clock gating register always read as 00.
// - bit 16 latches when system error raised for address parity error.
// - bit 17 latches for posted write data parity error.
// - bit 18 latches for posted write non-delivery after retry limit.
// - bit 19 latches for target abort during posted write delivery.
// - bit 20 latches for master abort during posted write delivery.
// - bit 21 latches for delayed write non-delivery after retry limit.
// - bit 22 latches for delayed read with no data after retry limit.
// - bit 23 latches when initiator failed to repeat before master timeout.
// - option bit 0 reads as 0 and resets to 0.
// - option bit 1 aliases primary memory read retry commands; resets 0.
// - option bit 2 aliases primary write-invalidate to write; resets 0.
// - option bit 3 aliases secondary memory read retry commands; resets 0.
// - system error for posted-write target abort needs mask clear and enable set.
package bcer_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] BCER_OFS_CLOCK_STATUS = 8'h68;
  localparam logic [7:0] BCER_OFS_PORT_OPTION = 8'h74;
  localparam int BCER_NUM_GATED = 4;
  localparam int BCER_NUM_SINGLE = 6;
  localparam int BCER_NUM_CLOCKS = 10;
  localparam int BCER_NUM_CAUSES = 8;
  localparam int BCER_POS_SINGLE = 8;
  localparam int BCER_POS_CAUSES = 16;
  localparam int BCER_CAUSE_TARGET_ABORT = 3;
  localparam int BCER_OPT_PRI_MEMR = 1;
  localparam int BCER_OPT_PRI_MEMW = 2;
  localparam int BCER_OPT_SEC_MEMR = 3;
  localparam logic [13:0] BCER_RST_CLOCK_GATING = 14'h0000;
  localparam logic [7:0] BCER_RST_CAUSES = 8'h00;
  localparam logic [3:1] BCER_RST_OPTIONS = 3'h0;
  localparam logic [9:0] BCER_RST_CLOCK_ENABLE = 10'h3ff;
  localparam logic [31:0] BCER_RST_READ_DATA = 32'h00000000;

  typedef struct packed {
    logic [13:0] clock_gating;
    logic [7:0] causes;
    logic [3:1] options;
    logic [31:0] read_data;
    logic [9:0] clock_enable;
    logic primary_system_error_out;
  } bcer_state_type;
endpackage : bcer_pkg

/* sim/bcer_host.sv */
`timescale 1ns/1ns
module bcer_host (
  input wire logic sys_clk,
  output logic cfg_write,
  output logic cfg_read,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_byte_en,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata
);
  initial begin
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_addr = 8'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0;
  end
  // ********
  // one configuration access
  // ********
  task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    cfg_write <= wr;
    cfg_read <= ~wr;
    cfg_addr <= a;
    cfg_byte_en <= be;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_write <= 1'b0;
    cfg_read <= 1'b0;
    // released lines do not keep the last value
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
    @(negedge sys_clk);
    q = cfg_rdata;
  endtask : acc
endmodule : bcer_host

/* sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top import bcer_pkg::*; ;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] error_events = 8'h00;
  logic [7:0] error_mask = 8'h00;
  logic system_error_enable = 1'b1;
  logic clk_en = 1'b1;
  logic cfg_write, cfg_read, primary_system_error_out, primary_memr_alias, primary_memw_alias, secondary_memr_alias;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [9:0] secondary_clock_outputs;
  int errors = 0;
  int n_compared = 0;
  always #50 sys_clk = ~sys_clk;
  bcer_regs u_bcer_regs (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .cfg_write(cfg_write),
    .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .error_events(error_events), .error_mask(error_mask), .system_error_enable(system_error_enable),
    .secondary_clock_outputs(secondary_clock_outputs), .primary_system_error_out(primary_system_error_out),
    .primary_memr_alias(primary_memr_alias), .primary_memw_alias(primary_memw_alias),
    .secondary_memr_alias(secondary_memr_alias));
  bcer_host u_bcer_host (.sys_clk(sys_clk), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  // ********
  // helpers and scenarios
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_bcer_host.acc(1'b0, a, 4'h0, 32'h0, q);
    chk(q, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    u_bcer_host.acc(1'b1, a, be, d, q);
  endtask : wr
  task automatic clk_chk(input logic [9:0] exp);
    @(posedge sys_clk);
    #10;
    chk({22'h0, secondary_clock_outputs}, {22'h0, exp});
  endtask : clk_chk
  task automatic pulse(input logic [7:0] ev, input logic exp_out);
    @(posedge sys_clk);
    error_events <= ev;
    @(posedge sys_clk);
    error_events <= 8'h00;
    #10;
    chk({31'h0, primary_system_error_out}, {31'h0, exp_out});
  endtask : pulse
  task automatic t_reset;
    rd(BCER_OFS_CLOCK_STATUS, 32'h0);
    rd(BCER_OFS_PORT_OPTION, 32'h0);
    clk_chk(10'h3ff);
    $display("reset test done");
  endtask : t_reset
  task automatic t_clocks;
    wr(BCER_OFS_CLOCK_STATUS, 4'h3, 32'hffff);
    rd(BCER_OFS_CLOCK_STATUS, 32'h3fff);
    clk_chk(10'h000);
    wr(BCER_OFS_CLOCK_STATUS, 4'h3, 32'h03e9);
    clk_chk(10'h3c7);
    $display("clock gating test done");
  endtask : t_clocks
  task automatic t_errors;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 1'b1);
      rd(BCER_OFS_CLOCK_STATUS, {8'h00, 8'hff >> (7 - i), 16'h03e9});
    end
    wr(BCER_OFS_CLOCK_STATUS, 4'h4, 32'h0008_0000);
    rd(BCER_OFS_CLOCK_STATUS, 32'h00f7_03e9);
    wr(BCER_OFS_CLOCK_STATUS, 4'h4, 32'h0);
    rd(BCER_OFS_CLOCK_STATUS, 32'h00f7_03e9);
    @(posedge sys_clk);
    error_mask <= 8'h08;
    pulse(8'h08, 1'b0);
    @(posedge sys_clk);
    error_mask <= 8'h00;
    system_error_enable <= 1'b0;
    pulse(8'h08, 1'b0);
    @(posedge sys_clk);
    system_error_enable <= 1'b1;
    rd(BCER_OFS_CLOCK_STATUS, 32'h00f7_03e9);
    $display("error flag test done");
  endtask : t_errors
  task automatic t_options;
    wr(BCER_OFS_PORT_OPTION, 4'h1, 32'hff);
    rd(BCER_OFS_PORT_OPTION, 32'he);
    chk({29'h0, primary_memr_alias, primary_memw_alias, secondary_memr_alias}, 32'h7);
    wr(BCER_OFS_PORT_OPTION, 4'h1, 32'h5);
    chk({29'h0, primary_memr_alias, primary_memw_alias, secondary_memr_alias}, 32'h2);
    rd(8'h70, 32'h0);
    $display("port option test done");
  endtask : t_options
  task automatic t_freeze;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(BCER_OFS_PORT_OPTION, 4'h1, 32'he);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(BCER_OFS_PORT_OPTION, 32'h4);
    $display("clock enable test done");
  endtask : t_freeze
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_clocks();
    t_errors();
    t_options();
    t_freeze();
    summarize();
  end
  initial begin
    #300000;
    errors++;
    summarize();
  end
endmodule : tb_top
